//--- rtl/fdi_i2c_port.sv
/*
  bus target port and register file of a two-channel flash led driver.
  assumes scl and sda arrive already synchronous to CLK (250 MHz), the
  board resolves the open-drain sda wire from SDA_OUT/SDA_OE, and fault
  event inputs are one-cycle pulses or levels from the analog side.
*/
`timescale 1ns/10ps
`default_nettype none

module fdi_i2c_port #(
  parameter logic [7:0] PART_IDENTITY = 8'h5a  // arbitrary value
) (
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             RSTN,
  // hardware enable pin, low holds the registers at default
  input  wire logic             HARDWARE_ENABLE_PIN,
  // serial bus, open drain data
  input  wire logic             SCL_IN,
  input  wire logic             SDA_IN,
  output logic                  SDA_OUT,
  output logic                  SDA_OE,
  // fault events from the protection logic
  input  wire logic [7:0]       FAULT_EVENTS_FIRST,
  input  wire logic [7:0]       FAULT_EVENTS_SECOND,
  // settings towards the driver logic
  output fdi_pkg::fdi_ctrl_t    CONTROL_SETTING,
  output fdi_pkg::fdi_guard_t   LOW_INPUT_GUARD_SETTING,
  output logic [7:0]            CHAN_A_FLASH_LEVEL,
  output logic [7:0]            CHAN_B_FLASH_LEVEL,
  output logic [7:0]            CHAN_A_TORCH_LEVEL,
  output logic [7:0]            CHAN_B_TORCH_LEVEL,
  output logic [7:0]            CONVERTER_CONFIG,
  output logic [7:0]            RAMP_AND_TIMEOUT,
  output logic [7:0]            FAULT_FLAGS_FIRST,
  output logic [7:0]            FAULT_FLAGS_SECOND
);

  // ----------------------------------------------------------------
  // types and state
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,   // waiting for a start
    ST_RECV = 5'b00010,   // shifting a byte in
    ST_ACK  = 5'b00100,   // driving our acknowledge
    ST_SEND = 5'b01000,   // shifting a byte out
    ST_MACK = 5'b10000    // sampling the controller acknowledge
  } fdi_state_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'h0,       // next byte is the target address
    PH_PTR  = 2'h1,       // next byte is the register pointer
    PH_DATA = 2'h2        // next byte is write data
  } fdi_phase_t;

  fdi_state_t  state_reg;               // bus engine state
  fdi_phase_t  phase_reg;               // meaning of received byte
  logic        scl_reg;                 // scl one cycle ago
  logic        sda_reg;                 // sda one cycle ago
  logic [3:0]  cnt_reg;                 // bits seen in this byte
  logic [7:0]  rx_reg;                  // receive shifter
  logic [7:0]  tx_reg;                  // transmit shifter
  logic        rw_reg;                  // direction of this transfer
  logic        mack_reg;                // controller acknowledged
  logic        sda_oe_reg;              // pulling sda low
  logic [7:0]  ptr_reg;                 // register pointer
  logic        sw_rst_reg;              // software reset pulse
  logic [7:0]  cfg_reg [0:fdi_pkg::REG_COUNT-1];  // writable registers
  logic [7:0]  fault_first_reg;         // sticky fault flags, first
  logic [7:0]  fault_second_reg;        // sticky fault flags, second

  // ----------------------------------------------------------------
  // bus condition decode
  // ----------------------------------------------------------------
  logic        scl_rise;                // sample point
  logic        scl_fall;                // drive point
  logic        start_cond;              // start or repeated start
  logic        stop_cond;               // stop
  logic        byte_done;               // eighth bit finished
  logic        wr_stb;                  // store a data byte
  logic        ptr_stb;                 // load the pointer
  logic        first_load;              // first read byte
  logic        next_load;               // following read byte
  logic        load_stb;                // any read byte load
  logic [7:0]  ld_ptr;                  // offset being read
  logic [7:0]  rd_byte;                 // value being read
  logic        regs_clear;              // return to defaults
  logic        clr_first;               // first fault register read
  logic        clr_second;              // second fault register read

  // clock edge, start and stop detect
  // sda moving while scl stays high is a bus condition, not data
  always_comb begin
    scl_rise   = SCL_IN & ~scl_reg;
    scl_fall   = ~SCL_IN & scl_reg;
    start_cond = SCL_IN & scl_reg & sda_reg & ~SDA_IN;
    stop_cond  = SCL_IN & scl_reg & ~sda_reg & SDA_IN;
  end

  // strobes derived from the engine, valid only while enabled
  always_comb begin
    byte_done  = HARDWARE_ENABLE_PIN & (state_reg == ST_RECV) & scl_fall
                 & (cnt_reg == fdi_pkg::BITS_PER_BYTE);
    wr_stb     = byte_done & (phase_reg == PH_DATA);
    ptr_stb    = byte_done & (phase_reg == PH_PTR);
    first_load = HARDWARE_ENABLE_PIN & (state_reg == ST_ACK) & scl_fall
                 & (phase_reg == PH_ADDR) & (rw_reg == fdi_pkg::DIR_READ);
    next_load  = HARDWARE_ENABLE_PIN & (state_reg == ST_MACK) & scl_fall
                 & mack_reg;
    load_stb   = first_load | next_load;
    ld_ptr     = next_load ? 8'(ptr_reg + 8'h01) : ptr_reg;
  end

  // read multiplexer; unmapped offsets read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (ld_ptr == fdi_pkg::OFF_FAULT_FIRST) begin
      rd_byte = fault_first_reg;
    end else if (ld_ptr == fdi_pkg::OFF_FAULT_SECOND) begin
      rd_byte = fault_second_reg;
    end else if (ld_ptr == fdi_pkg::OFF_IDENTITY) begin
      rd_byte = PART_IDENTITY;
    end else if (ld_ptr < 8'(fdi_pkg::REG_COUNT)) begin
      rd_byte = cfg_reg[ld_ptr[3:0]];
    end
  end

  // clear on read
  // flags clear when the byte holding them is loaded for sending
  always_comb begin
    clr_first  = load_stb & (ld_ptr == fdi_pkg::OFF_FAULT_FIRST);
    clr_second = load_stb & (ld_ptr == fdi_pkg::OFF_FAULT_SECOND);
  end

  // reset sources
  // enable pin low or software reset both restore the defaults
  always_comb begin
    regs_clear = ~HARDWARE_ENABLE_PIN | sw_rst_reg;
  end

  // ----------------------------------------------------------------
  // line history
  // ----------------------------------------------------------------
  // idle bus is high on both lines
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= SCL_IN;
      sda_reg <= SDA_IN;
    end
  end

  // ----------------------------------------------------------------
  // bus engine
  // ----------------------------------------------------------------
  // target only
  // scl is never driven; rates up to fast mode leave hundreds of
  // clock cycles per phase, so one-cycle edge decode is ample
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg  <= ST_IDLE;
      phase_reg  <= PH_ADDR;
      cnt_reg    <= 4'h0;
      rx_reg     <= 8'h00;
      tx_reg     <= 8'h00;
      rw_reg     <= fdi_pkg::DIR_WRITE;
      mack_reg   <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (!HARDWARE_ENABLE_PIN) begin
      // disabled part ignores the bus
      state_reg  <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (start_cond) begin
      state_reg  <= ST_RECV;
      phase_reg  <= PH_ADDR;
      cnt_reg    <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_cond) begin
      state_reg  <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_RECV: begin
          if (scl_rise) begin
            rx_reg  <= {rx_reg[6:0], SDA_IN};
            cnt_reg <= 4'(cnt_reg + 4'h1);
          end else if (byte_done) begin
            case (phase_reg)
              PH_ADDR: begin
                if (rx_reg[7:1] == fdi_pkg::TARGET_ADDR) begin
                  rw_reg     <= rx_reg[0];
                  sda_oe_reg <= 1'b1;
                  state_reg  <= ST_ACK;
                end else begin
                  // not ours, stay off the bus
                  state_reg <= ST_IDLE;
                end
              end
              default: begin
                sda_oe_reg <= 1'b1;
                state_reg  <= ST_ACK;
              end
            endcase
          end
        end
        ST_ACK: begin
          // low held through the whole ninth high phase
          if (scl_fall) begin
            cnt_reg <= 4'h0;
            if (first_load) begin
              // read: first bit goes out right away
              sda_oe_reg <= ~rd_byte[7];
              tx_reg     <= {rd_byte[6:0], 1'b0};
              state_reg  <= ST_SEND;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= ST_RECV;
              if (phase_reg == PH_ADDR) begin
                phase_reg <= PH_PTR;
              end else begin
                phase_reg <= PH_DATA;
              end
            end
          end
        end
        ST_SEND: begin
          if (scl_rise) begin
            cnt_reg <= 4'(cnt_reg + 4'h1);
          end else if (scl_fall) begin
            if (cnt_reg == fdi_pkg::BITS_PER_BYTE) begin
              // release for the controller acknowledge
              sda_oe_reg <= 1'b0;
              state_reg  <= ST_MACK;
            end else begin
              sda_oe_reg <= ~tx_reg[7];
              tx_reg     <= {tx_reg[6:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_reg <= ~SDA_IN;
          end else if (scl_fall) begin
            if (mack_reg) begin
              cnt_reg    <= 4'h0;
              sda_oe_reg <= ~rd_byte[7];
              tx_reg     <= {rd_byte[6:0], 1'b0};
              state_reg  <= ST_SEND;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= ST_IDLE;
            end
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
          state_reg  <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register pointer
  // ----------------------------------------------------------------
  // pointer survives a stop so a later read can rely on it; it wraps
  // past 0xff, and unmapped offsets on the way read as zero
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ptr_reg <= 8'h00;
    end else if (ptr_stb) begin
      ptr_reg <= rx_reg;
    end else if (wr_stb) begin
      ptr_reg <= 8'(ptr_reg + 8'h01);
    end else if (next_load) begin
      ptr_reg <= ld_ptr;
    end
  end

  // ----------------------------------------------------------------
  // software reset
  // ----------------------------------------------------------------
  // one-cycle pulse from a write of converter bit 7
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sw_rst_reg <= 1'b0;
    end else begin
      sw_rst_reg <= wr_stb & (ptr_reg == fdi_pkg::OFF_CONVERTER)
                    & rx_reg[7];
    end
  end

  // ----------------------------------------------------------------
  // writable register file
  // ----------------------------------------------------------------
  // mode field
  // guard behaviour
  // every field except converter bit 7 is stored as written; reserved bits keep what
  // software put there, which it is expected to keep at zero
  genvar gi;
  generate
    for (gi = 0; gi < fdi_pkg::REG_COUNT; gi++) begin : g_cfg
      localparam logic [7:0] DEF = fdi_pkg::reg_default(gi);
      localparam logic       WRITABLE = fdi_pkg::reg_writable(gi);
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          cfg_reg[gi] <= DEF;
        end else if (regs_clear) begin
          cfg_reg[gi] <= DEF;
        end else if (wr_stb && WRITABLE && (ptr_reg == 8'(gi))) begin
          if (8'(gi) == fdi_pkg::OFF_CONVERTER) begin
            cfg_reg[gi] <= rx_reg & ~fdi_pkg::SWRST_MASK;
          end else begin
            cfg_reg[gi] <= rx_reg;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // fault flags
  // ----------------------------------------------------------------
  // set by events, cleared by read or reset
  // an event in the cycle of the read clear wins and stays visible
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fault_first_reg  <= fdi_pkg::RST_FAULT;
      fault_second_reg <= fdi_pkg::RST_FAULT;
    end else if (regs_clear) begin
      fault_first_reg  <= fdi_pkg::RST_FAULT;
      fault_second_reg <= fdi_pkg::RST_FAULT;
    end else begin
      fault_first_reg  <= (fault_first_reg & ~{8{clr_first}})
                          | (FAULT_EVENTS_FIRST & fdi_pkg::FAULT_FIRST_MASK);
      fault_second_reg <= (fault_second_reg & ~{8{clr_second}})
                          | (FAULT_EVENTS_SECOND & fdi_pkg::FAULT_SECOND_MASK);
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  // open drain: the data level is always low, only the enable moves
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      SDA_OUT <= 1'b0;
    end else begin
      SDA_OUT <= 1'b0;
    end
  end

  assign SDA_OE                  = sda_oe_reg;
  assign CONTROL_SETTING         = fdi_pkg::fdi_ctrl_t'(cfg_reg[1]);
  assign LOW_INPUT_GUARD_SETTING = fdi_pkg::fdi_guard_t'(cfg_reg[2]);
  assign CHAN_A_FLASH_LEVEL      = cfg_reg[3];
  assign CHAN_B_FLASH_LEVEL      = cfg_reg[4];
  assign CHAN_A_TORCH_LEVEL      = cfg_reg[5];
  assign CHAN_B_TORCH_LEVEL      = cfg_reg[6];
  assign CONVERTER_CONFIG        = cfg_reg[7];
  assign RAMP_AND_TIMEOUT        = cfg_reg[8];
  assign FAULT_FLAGS_FIRST       = fault_first_reg;
  assign FAULT_FLAGS_SECOND      = fault_second_reg;

endmodule

`default_nettype wire

//--- rtl/fdi_pkg.sv
/*
  constants, types and default tables for the flash driver register port.
  assumes a single 250 MHz clock domain; no other files are needed.
*/
package fdi_pkg;

  // ----------------------------------------------------------------
  // bus addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR = 7'h63;   // 1100011
  localparam logic       DIR_WRITE   = 1'b0;
  localparam logic       DIR_READ    = 1'b1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam int         REG_COUNT       = 16;
  localparam logic [7:0] OFF_CONTROL     = 8'h01;
  localparam logic [7:0] OFF_GUARD       = 8'h02;
  localparam logic [7:0] OFF_A_FLASH     = 8'h03;
  localparam logic [7:0] OFF_B_FLASH     = 8'h04;
  localparam logic [7:0] OFF_A_TORCH     = 8'h05;
  localparam logic [7:0] OFF_B_TORCH     = 8'h06;
  localparam logic [7:0] OFF_CONVERTER   = 8'h07;
  localparam logic [7:0] OFF_RAMP        = 8'h08;
  localparam logic [7:0] OFF_FAULT_FIRST = 8'h0a;
  localparam logic [7:0] OFF_FAULT_SECOND = 8'h0b;
  localparam logic [7:0] OFF_IDENTITY    = 8'h0c;

  // ----------------------------------------------------------------
  // reset values and field masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL   = 8'h80;
  localparam logic [7:0] RST_GUARD     = 8'h01;
  localparam logic [7:0] RST_A_FLASH   = 8'hbf;
  localparam logic [7:0] RST_B_FLASH   = 8'h3f;
  localparam logic [7:0] RST_A_TORCH   = 8'hbf;
  localparam logic [7:0] RST_B_TORCH   = 8'h3f;
  localparam logic [7:0] RST_CONVERTER = 8'h09;
  localparam logic [7:0] RST_RAMP      = 8'h1a;
  localparam logic [7:0] RST_FAULT     = 8'h00;
  localparam logic [7:0] SWRST_MASK    = 8'h80;  // converter bit 7
  localparam logic [7:0] FAULT_FIRST_MASK  = 8'h3f;
  localparam logic [7:0] FAULT_SECOND_MASK = 8'h06;

  // ----------------------------------------------------------------
  // control and guard field layouts
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_INFRARED = 2'h1,
    MODE_TORCH   = 2'h2,
    MODE_FLASH   = 2'h3
  } fdi_mode_t;

  typedef struct packed {
    logic      tx_pin_en;      // bit 7
    logic      trig_edge;      // bit 6: 0 level, 1 edge
    logic      flash_trig_en;  // bit 5
    logic      torch_trig_en;  // bit 4
    fdi_mode_t mode;           // bits 3:2
    logic      chan_two_en;    // bit 1
    logic      chan_one_en;    // bit 0
  } fdi_ctrl_t;

  typedef struct packed {
    logic [1:0] reserved;      // bits 7:6
    logic [2:0] threshold;     // bits 5:3, 2.9 V + code x 0.1 V
    logic       hysteresis;    // bit 2: 0 none, 1 50 mV
    logic [1:0] behaviour;     // bits 1:0
  } fdi_guard_t;

  // default of each writable offset, zero elsewhere
  function automatic logic [7:0] reg_default(input int idx);
    case (idx)
      1: reg_default = RST_CONTROL;
      2: reg_default = RST_GUARD;
      3: reg_default = RST_A_FLASH;
      4: reg_default = RST_B_FLASH;
      5: reg_default = RST_A_TORCH;
      6: reg_default = RST_B_TORCH;
      7: reg_default = RST_CONVERTER;
      8: reg_default = RST_RAMP;
      default: reg_default = 8'h00;
    endcase
  endfunction

  // offsets that accept writes
  function automatic logic reg_writable(input int idx);
    reg_writable = (idx >= 1) && (idx <= 8);
  endfunction

endpackage

//--- verification/fdi_bus_ctrl.sv
/*
  bus controller model: makes the clock and pulls data low.
  assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none
module fdi_bus_ctrl (
  // clock
  input  wire logic clk,
  // bus lines
  input  wire logic sda_wire,
  output var logic  scl,
  output var logic  sda_pull
);
  // idle bus: both lines high
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // four cycles a phase, above the three the port needs
  task automatic phase();
    repeat (4) @(posedge clk);
  endtask
  task automatic start();
    sda_pull <= 1'b0;
    phase();
    scl <= 1'b1;
    phase();
    sda_pull <= 1'b1;
    phase();
    scl <= 1'b0;
    phase();
  endtask
  task automatic stop();
    sda_pull <= 1'b1;
    phase();
    scl <= 1'b1;
    phase();
    sda_pull <= 1'b0;
    phase();
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_pull <= !b;
    phase();
    scl <= 1'b1;
    phase();
    s = sda_wire;
    scl <= 1'b0;
    phase();
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic get_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!mack, s);
  endtask
endmodule
`default_nettype wire

//--- verification/fdi_i2c_port_bench.sv
/*
  testbench: register traffic over the serial port, checked at the pins.
  assumes fdi_bus_ctrl as controller and a pulled-up data wire.
*/
`timescale 1ns/10ps
`default_nettype none
module fdi_i2c_port_bench;
  localparam logic [7:0] ID = 8'ha5;  // arbitrary identity value
  localparam logic [7:0] AW = {fdi_pkg::TARGET_ADDR, fdi_pkg::DIR_WRITE};
  localparam logic [7:0] AR = {fdi_pkg::TARGET_ADDR, fdi_pkg::DIR_READ};
  // expected contents of offsets 1 to 12
  localparam logic [7:0] DEF [1:12] = '{8'h80, 8'h01, 8'hbf, 8'h3f, 8'hbf, 8'h3f,
    8'h09, 8'h1a, 8'h00, 8'h00, 8'h00, ID};
  logic clk, rstn, hw_en, scl, sda_pull, sda, sda_oe, sda_o, ack;
  logic [7:0] ev1, ev2, fa, fb, ta, tb, conv, ramp, fl1, fl2, rd, c, g;
  logic [7:0] outs [1:8];
  fdi_pkg::fdi_ctrl_t ctrl;
  fdi_pkg::fdi_guard_t guard;
  int fail_count, cmp_count;
  assign sda = !(sda_pull || sda_oe);  // open drain with pull-up
  assign outs = '{ctrl, guard, fa, fb, ta, tb, conv, ramp};
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  fdi_i2c_port #(.PART_IDENTITY(ID)) fdi_i2c_port_i (.CLK(clk), .RSTN(rstn),
    .HARDWARE_ENABLE_PIN(hw_en), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE(sda_oe),
    .FAULT_EVENTS_FIRST(ev1), .FAULT_EVENTS_SECOND(ev2), .CONTROL_SETTING(ctrl),
    .LOW_INPUT_GUARD_SETTING(guard), .CHAN_A_FLASH_LEVEL(fa), .CHAN_B_FLASH_LEVEL(fb),
    .CHAN_A_TORCH_LEVEL(ta), .CHAN_B_TORCH_LEVEL(tb), .CONVERTER_CONFIG(conv),
    .RAMP_AND_TIMEOUT(ramp), .FAULT_FLAGS_FIRST(fl1), .FAULT_FLAGS_SECOND(fl2));
  fdi_bus_ctrl fdi_bus_ctrl_i (.clk(clk), .sda_wire(sda), .scl(scl), .sda_pull(sda_pull));
  // ----------
  // shared tasks
  // ----------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic [7:0] exp);
    fdi_bus_ctrl_i.put_byte(b, ack);
    chk("ack", exp, {7'h00, ack});
  endtask
  task automatic point(input logic [7:0] p);
    fdi_bus_ctrl_i.start();
    send(AW, 8'h01);
    send(p, 8'h01);
  endtask
  task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
    point(p);
    send(d, 8'h01);
    fdi_bus_ctrl_i.stop();
  endtask
  task automatic reg_rd(input logic [7:0] p);
    point(p);
    fdi_bus_ctrl_i.start();
    send(AR, 8'h01);
    fdi_bus_ctrl_i.get_byte(1'b0, rd);
    fdi_bus_ctrl_i.stop();
  endtask
  task automatic pulse_events();
    ev1 <= 8'hff;
    ev2 <= 8'hff;
    @(posedge clk);
    ev1 <= 8'h00;
    ev2 <= 8'h00;
    repeat (2) @(posedge clk);
  endtask
  task automatic chk_outs();
    for (int i = 1; i <= 8; i++) chk("setting", DEF[i], outs[i]);
    chk("flags", 8'h00, fl1 | fl2);
  endtask
  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------
  // main sequence
  // ----------
  initial begin
    rstn = 1'b0;
    hw_en = 1'b1;
    ev1 = 8'h00;
    ev2 = 8'h00;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    // burst read of offsets 1 to 12 after reset
    point(8'h01);
    fdi_bus_ctrl_i.start();
    send(AR, 8'h01);
    for (int i = 1; i <= 12; i++) begin
      fdi_bus_ctrl_i.get_byte(i < 12, rd);
      chk("read", DEF[i], rd);
    end
    fdi_bus_ctrl_i.stop();
    // every mode, threshold and behaviour, two-byte burst
    // trigger style is also rewritten while a trigger enable is set
    for (int k = 0; k < 8; k++) begin
      c = {k[0], k[1], k[2], k[0], k[1:0], k[2], k[1]};
      g = {2'b00, k[2:0], k[0], k[1:0]};  // reserved written as zero
      point(8'h01);
      send(c, 8'h01);
      send(g, 8'h01);
      fdi_bus_ctrl_i.stop();
      chk("control", c, ctrl);
      chk("guard", g, guard);
    end
    // read-only identity survives a write
    reg_wr(8'h0c, 8'h00);
    reg_rd(8'h0c);
    chk("identity", ID, rd);
    // foreign address is ignored
    fdi_bus_ctrl_i.start();
    send({7'h62, fdi_pkg::DIR_WRITE}, 8'h00);
    send(8'h01, 8'h00);
    send(8'h00, 8'h00);
    fdi_bus_ctrl_i.stop();
    chk("control kept", c, ctrl);
    // sticky flags cleared by reading
    pulse_events();
    chk("flags one", fdi_pkg::FAULT_FIRST_MASK, fl1);
    reg_rd(8'h0a);
    chk("read flags one", fdi_pkg::FAULT_FIRST_MASK, rd);
    reg_rd(8'h0b);
    chk("read flags two", fdi_pkg::FAULT_SECOND_MASK, rd);
    chk("flags cleared", 8'h00, fl1 | fl2);
    // software reset from a changed state
    pulse_events();
    reg_wr(8'h07, 8'h80);
    chk_outs();
    // enable pin low restores defaults
    reg_wr(8'h01, 8'h3c);
    pulse_events();
    hw_en <= 1'b0;
    repeat (2) @(posedge clk);
    hw_en <= 1'b1;
    @(posedge clk);
    chk_outs();
    stop_test();
  end
  // watchdog: the run needs about 8200 cycles
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire

//--- verification/fdi_port_props.sv
/*
  assertions on the serial port, setting and fault flag outputs of the register port.
  assumes one CLK domain and a bind onto fdi_i2c_port.
*/
`timescale 1ns/10ps
`default_nettype none
module fdi_port_props (
  // clock and reset
  input wire logic               CLK,
  input wire logic               RSTN,
  // pins
  input wire logic               HARDWARE_ENABLE_PIN,
  input wire logic               SCL_IN,
  input wire logic               SDA_OUT,
  input wire logic               SDA_OE,
  input wire logic [7:0]         FAULT_EVENTS_FIRST,
  // settings
  input wire fdi_pkg::fdi_ctrl_t CONTROL_SETTING,
  input wire logic [7:0]         CONVERTER_CONFIG,
  input wire logic [7:0]         FAULT_FLAGS_FIRST
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  AST_SDA_LOW:
    assert property (SDA_OUT == 1'b0) else $error("sda drive level not low");
  AST_OE_AFTER_FALL:
    assert property ($changed(SDA_OE) |-> (!$past(SCL_IN) && $past(SCL_IN, 2))
      || !$past(HARDWARE_ENABLE_PIN)) else $error("sda moved off the clock fall");
  AST_OE_HELD_HIGH:
    assert property ($rose(SCL_IN) && HARDWARE_ENABLE_PIN |=> $stable(SDA_OE) [*2])
      else $error("sda moved while clock high");
  AST_ENABLE_DEFAULTS:
    assert property (!HARDWARE_ENABLE_PIN |=> CONTROL_SETTING == fdi_pkg::RST_CONTROL
      && CONVERTER_CONFIG == fdi_pkg::RST_CONVERTER && FAULT_FLAGS_FIRST == 8'h00 && !SDA_OE)
      else $error("enable pin low kept settings");
  AST_FAULT_SET:
    assert property (HARDWARE_ENABLE_PIN |=> ((FAULT_FLAGS_FIRST & $past(FAULT_EVENTS_FIRST))
      & fdi_pkg::FAULT_FIRST_MASK) == ($past(FAULT_EVENTS_FIRST) & fdi_pkg::FAULT_FIRST_MASK))
      else $error("fault event not flagged");
  AST_FLAG_STICKY:
    assert property ($fell(FAULT_FLAGS_FIRST[0]) |-> !SCL_IN || !$past(SCL_IN)
      || !$past(HARDWARE_ENABLE_PIN)) else $error("fault flag dropped unread");
  AST_CTRL_WHEN:
    assert property ($changed(CONTROL_SETTING) |-> !$past(SCL_IN)
      || !$past(HARDWARE_ENABLE_PIN)) else $error("control changed outside a byte end");
  AST_SWRST_CLEAR:
    assert property (CONVERTER_CONFIG[7] == 1'b0) else $error("software reset bit stuck");
endmodule
bind fdi_i2c_port fdi_port_props fdi_port_props_i (.CLK(CLK), .RSTN(RSTN),
  .HARDWARE_ENABLE_PIN(HARDWARE_ENABLE_PIN), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .FAULT_EVENTS_FIRST(FAULT_EVENTS_FIRST), .CONTROL_SETTING(CONTROL_SETTING),
  .CONVERTER_CONFIG(CONVERTER_CONFIG), .FAULT_FLAGS_FIRST(FAULT_FLAGS_FIRST));
`default_nettype wire
